// *** core/tws_pkg.sv ***
package tws_pkg;

  // bus address bytes, write form; bit 0 carries the direction
  localparam logic [7:0] TWS_DEV_ADDR_STRAP_LO = 8'h90;
  localparam logic [7:0] TWS_DEV_ADDR_STRAP_HI = 8'hba;

  // byte framing
  localparam int         TWS_BYTE_MSB     = 7;
  localparam int         TWS_BIT_CNT_W    = 4;
  localparam logic [3:0] TWS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TWS_BIT_CNT_ZERO  = 4'h0;
  localparam logic [3:0] TWS_BIT_CNT_ONE   = 4'h1;
  localparam int         TWS_DIR_BIT      = 0;
  localparam logic       TWS_DIR_READ     = 1'b1;

  // register access port
  localparam int          TWS_REG_W       = 16;
  localparam logic [15:0] TWS_PTR_RESET   = 16'h0000;
  localparam logic [15:0] TWS_PTR_STEP    = 16'h0001;
  localparam logic [15:0] TWS_WORD_RESET  = 16'h0000;
  localparam logic [7:0]  TWS_BYTE_RESET  = 8'h00;

  // protocol state, gray along receive -> ack -> transmit -> master ack
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_ACK    = 3'h3,
    ST_TX     = 3'h2,
    ST_MACK   = 3'h6,
    ST_TXNEXT = 3'h7
  } tws_state_t;

  // which byte of the message is on the wire
  typedef enum logic [2:0] {
    PH_DEV = 3'h0,
    PH_AHI = 3'h1,
    PH_ALO = 3'h3,
    PH_DHI = 3'h2,
    PH_DLO = 3'h6,
    PH_RHI = 3'h7,
    PH_RLO = 3'h5
  } tws_phase_t;

endpackage : tws_pkg

// *** core/tws_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module tws_pin_sync
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // asynchronous pin
  input  wire logic pin_in,
  // filtered level and edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic agree;

  assign agree = (s2_reg == s3_reg);

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // edges decoded without a flop: the answer lands a cycle earlier in the low half
  assign rise = agree && s2_reg && !level;
  assign fall = agree && !s2_reg && level;

  // idle bus reads high, so reset level is high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level <= 1'b1;
    end
    else if (agree)
    begin
      level <= s2_reg;
    end
  end

endmodule : tws_pin_sync

`default_nettype wire

// *** core/tws_slave.sv ***
`timescale 1ns/1ns
`default_nettype none

module tws_slave
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // serial link
  input  wire logic                 serial_clock_line,
  input  wire logic                 serial_data_line_in,
  output logic                      serial_data_line_out,
  output logic                      serial_data_line_oe,
  input  wire logic                 bus_address_select_pin,
  // register access
  output logic [TWS_REG_W-1:0]      reg_addr,
  output logic [TWS_REG_W-1:0]      reg_wdata,
  output logic                      reg_wr_pulse,
  output logic                      reg_rd_pulse,
  input  wire logic [TWS_REG_W-1:0] reg_rdata,
  // status
  output logic                      bus_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  logic scl_level;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic sda_rise;
  logic sda_fall;
  logic strap_level;

  tws_pin_sync u_scl_sync
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (serial_clock_line),
    .level  (scl_level),
    .rise   (scl_rise),
    .fall   (scl_fall)
  );

  tws_pin_sync u_sda_sync
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (serial_data_line_in),
    .level  (sda_level),
    .rise   (sda_rise),
    .fall   (sda_fall)
  );

  // strap is a pin too; filtered like the link lines
  tws_pin_sync u_strap_sync
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (bus_address_select_pin),
    .level  (strap_level),
    .rise   (),
    .fall   ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions and decode

  tws_state_t                state_reg;
  tws_phase_t                phase_reg;
  logic [TWS_BIT_CNT_W-1:0]  bit_cnt_reg;
  logic [7:0]                rx_shift_reg;
  logic [7:0]                tx_shift_reg;
  logic [7:0]                rd_lo_reg;
  logic                      rd_dir_reg;
  logic [7:0]                addr_hi_reg;
  logic [7:0]                data_hi_reg;
  logic [TWS_REG_W-1:0]      ptr_reg;

  logic       start_cond;
  logic       stop_cond;
  logic [7:0] own_addr;
  logic       addr_match;
  logic       rx_done;
  logic       rd_word_done;

  // edges of both lines pass equal delay, so the levels still line up
  assign start_cond = sda_fall && scl_level;
  assign stop_cond  = sda_rise && scl_level;

  assign own_addr   = strap_level ? TWS_DEV_ADDR_STRAP_HI
                                  : TWS_DEV_ADDR_STRAP_LO;
  // only bits 7:1 are compared; bit 0 picks 0x90/0x91 style forms
  assign addr_match = (rx_shift_reg[TWS_BYTE_MSB:1] == own_addr[TWS_BYTE_MSB:1]);

  assign rx_done = (state_reg == ST_RX) && scl_fall
                   && (bit_cnt_reg == TWS_BITS_PER_BYTE);

  // low byte of a read word finished its master acknowledge slot
  assign rd_word_done = (state_reg == ST_MACK) && scl_rise && (phase_reg == PH_RLO);

  ////////////////////////////////////////////////////////////////////////////
  // bus busy flag

  // idle means both lines high after a stop; reset assumes an idle bus
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_busy <= 1'b0;
    end
    else if (start_cond)
    begin
      bus_busy <= 1'b1;
    end
    else if (stop_cond)
    begin
      bus_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg           <= ST_IDLE;
      phase_reg           <= PH_DEV;
      bit_cnt_reg         <= TWS_BIT_CNT_ZERO;
      rx_shift_reg        <= TWS_BYTE_RESET;
      tx_shift_reg        <= TWS_BYTE_RESET;
      rd_lo_reg           <= TWS_BYTE_RESET;
      rd_dir_reg          <= 1'b0;
      serial_data_line_oe <= 1'b0;
      reg_rd_pulse        <= 1'b0;
    end
    else
    begin
      reg_rd_pulse <= 1'b0;
      if (start_cond)
      begin
        // a restart aborts whatever was in flight
        state_reg           <= ST_RX;
        phase_reg           <= PH_DEV;
        bit_cnt_reg         <= TWS_BIT_CNT_ZERO;
        serial_data_line_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_reg           <= ST_IDLE;
        phase_reg           <= PH_DEV;
        serial_data_line_oe <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          ST_IDLE:
          begin
            serial_data_line_oe <= 1'b0;
          end
          ST_RX:
          begin
            if (scl_rise)
            begin
              // sampled at the filtered rising clock edge while the line is stable
              rx_shift_reg <= {rx_shift_reg[TWS_BYTE_MSB-1:0], sda_level};
              bit_cnt_reg  <= bit_cnt_reg + TWS_BIT_CNT_ONE;
            end
            else if (rx_done)
            begin
              if (phase_reg == PH_DEV)
              begin
                rd_dir_reg <= (rx_shift_reg[TWS_DIR_BIT] == TWS_DIR_READ);
                if (addr_match)
                begin
                  serial_data_line_oe <= 1'b1;
                  state_reg           <= ST_ACK;
                end
                else
                begin
                  // foreign address: stay released until the next start
                  state_reg <= ST_IDLE;
                end
              end
              else
              begin
                serial_data_line_oe <= 1'b1;
                state_reg           <= ST_ACK;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              serial_data_line_oe <= 1'b0;
              bit_cnt_reg         <= TWS_BIT_CNT_ZERO;
              unique case (phase_reg)
                PH_DEV:
                begin
                  if (rd_dir_reg)
                  begin
                    // read starts at the current pointer
                    tx_shift_reg        <= reg_rdata[TWS_REG_W-1:8];
                    rd_lo_reg           <= reg_rdata[7:0];
                    reg_rd_pulse        <= 1'b1;
                    serial_data_line_oe <= !reg_rdata[TWS_REG_W-1];
                    phase_reg           <= PH_RHI;
                    state_reg           <= ST_TX;
                  end
                  else
                  begin
                    phase_reg <= PH_AHI;
                    state_reg <= ST_RX;
                  end
                end
                PH_AHI:
                begin
                  phase_reg <= PH_ALO;
                  state_reg <= ST_RX;
                end
                PH_ALO:
                begin
                  phase_reg <= PH_DHI;
                  state_reg <= ST_RX;
                end
                PH_DHI:
                begin
                  phase_reg <= PH_DLO;
                  state_reg <= ST_RX;
                end
                default:
                begin
                  // word written, take further words until stop or restart
                  phase_reg <= PH_DHI;
                  state_reg <= ST_RX;
                end
              endcase
            end
          end
          ST_TX:
          begin
            if (scl_rise)
            begin
              bit_cnt_reg <= bit_cnt_reg + TWS_BIT_CNT_ONE;
            end
            else if (scl_fall)
            begin
              if (bit_cnt_reg == TWS_BITS_PER_BYTE)
              begin
                serial_data_line_oe <= 1'b0;
                state_reg           <= ST_MACK;
              end
              else
              begin
                // next bit changes only while the clock is low
                tx_shift_reg        <= {tx_shift_reg[TWS_BYTE_MSB-1:0], 1'b0};
                serial_data_line_oe <= !tx_shift_reg[TWS_BYTE_MSB-1];
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
            begin
              if (sda_level)
              begin
                state_reg <= ST_IDLE;
              end
              else
              begin
                state_reg <= ST_TXNEXT;
              end
            end
          end
          ST_TXNEXT:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= TWS_BIT_CNT_ZERO;
              state_reg   <= ST_TX;
              if (phase_reg == PH_RHI)
              begin
                tx_shift_reg        <= rd_lo_reg;
                serial_data_line_oe <= !rd_lo_reg[TWS_BYTE_MSB];
                phase_reg           <= PH_RLO;
              end
              else
              begin
                // pointer already stepped at the last acknowledge
                tx_shift_reg        <= reg_rdata[TWS_REG_W-1:8];
                rd_lo_reg           <= reg_rdata[7:0];
                reg_rd_pulse        <= 1'b1;
                serial_data_line_oe <= !reg_rdata[TWS_REG_W-1];
                phase_reg           <= PH_RHI;
              end
            end
          end
          default:
          begin
            state_reg           <= ST_IDLE;
            serial_data_line_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register pointer and write port

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_hi_reg  <= TWS_BYTE_RESET;
      data_hi_reg  <= TWS_BYTE_RESET;
      ptr_reg      <= TWS_PTR_RESET;
      reg_wdata    <= TWS_WORD_RESET;
      reg_wr_pulse <= 1'b0;
    end
    else
    begin
      reg_wr_pulse <= 1'b0;
      if (rx_done && (phase_reg == PH_AHI))
      begin
        addr_hi_reg <= rx_shift_reg;
      end
      if (rx_done && (phase_reg == PH_ALO))
      begin
        ptr_reg <= {addr_hi_reg, rx_shift_reg};
      end
      else if (reg_wr_pulse || rd_word_done)
      begin
        // step after the strobe so the write sees the old address
        ptr_reg <= ptr_reg + TWS_PTR_STEP;
      end
      if (rx_done && (phase_reg == PH_DHI))
      begin
        data_hi_reg <= rx_shift_reg;
      end
      if (rx_done && (phase_reg == PH_DLO))
      begin
        reg_wdata    <= {data_hi_reg, rx_shift_reg};
        reg_wr_pulse <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_addr = ptr_reg;

  // open drain: only ever pulls low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_data_line_out <= 1'b0;
    end
    else
    begin
      serial_data_line_out <= 1'b0;
    end
  end

endmodule : tws_slave

`default_nettype wire

// *** dv/tws_slave_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module tws_slave_monitor
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // serial link
  input wire logic        serial_clock_line,
  input wire logic        serial_data_line_in,
  input wire logic        serial_data_line_out,
  input wire logic        serial_data_line_oe,
  // register port and status
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr_pulse,
  input wire logic        reg_rd_pulse,
  input wire logic        bus_busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////
  property p_out_low;
    !serial_data_line_out;
  endproperty
  a_out_low: assert property (p_out_low) else $error("data line driven high");
  property p_ack_hold;
    $rose(serial_data_line_oe) |-> serial_data_line_oe [*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull-down too short");
  property p_oe_clk_low;
    $changed(serial_data_line_oe) |-> !serial_clock_line;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved, clock high");
  property p_start_busy;
    serial_clock_line && $past(serial_clock_line) && $fell(serial_data_line_in)
      |-> ##[1:6] bus_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not seen");
  property p_stop_idle;
    serial_clock_line && $past(serial_clock_line) && $rose(serial_data_line_in)
      |-> ##[1:6] !bus_busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
  property p_idle_released;
    !bus_busy |-> !serial_data_line_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle bus pulled");
  property p_wr_once;
    reg_wr_pulse |-> bus_busy ##1 !reg_wr_pulse;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write pulse bad");
  property p_rd_once;
    reg_rd_pulse |-> bus_busy ##1 !reg_rd_pulse;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read pulse bad");
  property p_ptr_step;
    reg_wr_pulse |=> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");

  c_wr: cover property (reg_wr_pulse);
  c_rd: cover property (reg_rd_pulse);
  c_ack: cover property ($rose(serial_data_line_oe));
  c_stop: cover property ($fell(bus_busy));
endmodule : tws_slave_monitor

bind tws_slave tws_slave_monitor u_mon (
  .clock(clock), .rst_n(rst_n), .serial_clock_line(serial_clock_line),
  .serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe), .reg_addr(reg_addr),
  .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse), .bus_busy(bus_busy)
);

`default_nettype wire

// *** dv/tws_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module tws_master_model
(
  // system clock paces the link
  input  wire logic clock,
  // resolved data wire
  input  wire logic sda_line,
  // link clock and open-drain data, 1 = released
  output var logic  scl,
  output var logic  sda_rel
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // link period of 8 clocks: low 5, high 3; long low half leaves room for slave lag
  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_rel <= b;
    tick(4);
    scl <= 1'b1;
    tick(1);
    r = sda_line;
    tick(2);
    scl <= 1'b0;
  endtask : bit_x

  task automatic start_cond();
    tick(1);
    sda_rel <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(3);
    sda_rel <= 1'b0;
    tick(3);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(1);
    sda_rel <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(3);
    sda_rel <= 1'b1;
    tick(4);
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask : put_byte

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(mack, r);
  endtask : get_byte
endmodule : tws_master_model

`default_nettype wire

// *** dv/tws_slave_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module tws_slave_bench
  import tws_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap = 1'b0;
  logic        scl, sda_rel, sda_line, oe, out, busy, wr, rd, nak;
  logic [15:0] addr, wdata, rdata;
  logic [15:0] wa_q[$], wd_q[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  int          rd_cnt = 0;

  always #25 clock = ~clock;
  assign sda_line = sda_rel & (~oe | out);
  // register file stand-in: contents derived from the address
  assign rdata = addr ^ 16'h5aa5;

  tws_master_model u_master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  tws_slave dut (
    .clock(clock), .rst_n(rst_n), .serial_clock_line(scl), .serial_data_line_in(sda_line),
    .serial_data_line_out(out), .serial_data_line_oe(oe), .bus_address_select_pin(strap),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr_pulse(wr), .reg_rd_pulse(rd),
    .reg_rdata(rdata), .bus_busy(busy)
  );

  always @(posedge clock)
  begin
    if (rd === 1'b1)
      rd_cnt++;
    if (wr === 1'b1)
    begin
      wa_q.push_back(addr);
      wd_q.push_back(wdata);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [7:0] b);
    logic a;
    u_master.put_byte(b, a);
    nak = nak | a;
  endtask : send

  task automatic chk_wr(input logic [15:0] a, input logic [15:0] d);
    chk("write addr", wa_q.pop_front(), a);
    chk("write data", wd_q.pop_front(), d);
  endtask : chk_wr

  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    nak = 1'b0;
    u_master.start_cond();
    // filter lag: the flag settles a few cycles after the line moves
    u_master.tick(2);
    chk("busy on start", 16'(busy), 16'h1);
    send(TWS_DEV_ADDR_STRAP_LO);
    send(8'h12);
    send(8'h34);
    send(8'hab);
    send(8'hcd);
    u_master.stop_cond();
    u_master.tick(2);
    chk("busy on stop", 16'(busy), 16'h0);
    chk("write acks", 16'(nak), 16'h0);
    chk("write count", 16'(wa_q.size()), 16'h1);
    chk_wr(16'h1234, 16'habcd);
  endtask : t_write

  // two words then a lone high byte, which must be dropped
  task automatic t_seq_write();
    nak = 1'b0;
    u_master.start_cond();
    send(8'h90);
    send(8'h00);
    send(8'hfe);
    send(8'h11);
    send(8'h11);
    send(8'h22);
    send(8'h22);
    send(8'h33);
    u_master.stop_cond();
    chk("seq acks", 16'(nak), 16'h0);
    chk("seq count", 16'(wa_q.size()), 16'h2);
    chk_wr(16'h00fe, 16'h1111);
    chk_wr(16'h00ff, 16'h2222);
  endtask : t_seq_write

  task automatic t_rand_read();
    logic [7:0] hi, lo;
    nak = 1'b0;
    u_master.start_cond();
    send(8'h90);
    send(8'h01);
    send(8'h00);
    u_master.start_cond();
    send(8'h91);
    u_master.get_byte(1'b0, hi);
    u_master.get_byte(1'b1, lo);
    u_master.stop_cond();
    chk("rand acks", 16'(nak), 16'h0);
    chk("rand word", {hi, lo}, 16'h0100 ^ 16'h5aa5);
    chk("ptr after read", addr, 16'h0101);
  endtask : t_rand_read

  task automatic t_cur_read();
    logic [7:0] b0, b1, b2, b3;
    int         rd0;
    nak = 1'b0;
    rd0 = rd_cnt;
    u_master.start_cond();
    send(8'h91);
    u_master.get_byte(1'b0, b0);
    u_master.get_byte(1'b0, b1);
    u_master.get_byte(1'b0, b2);
    u_master.get_byte(1'b1, b3);
    u_master.stop_cond();
    chk("cur ack", 16'(nak), 16'h0);
    chk("cur word 0", {b0, b1}, 16'h0101 ^ 16'h5aa5);
    chk("cur word 1", {b2, b3}, 16'h0102 ^ 16'h5aa5);
    chk("cur rd pulses", 16'(rd_cnt - rd0), 16'h2);
  endtask : t_cur_read

  // both straps against both address bytes, then a read at the alternate address
  task automatic t_strap();
    logic       a;
    logic [7:0] d;
    logic [15:0] e;
    for (int i = 0; i < 4; i++)
    begin
      strap <= i[1];
      u_master.tick(8);
      u_master.start_cond();
      u_master.put_byte(i[0] ? TWS_DEV_ADDR_STRAP_HI : TWS_DEV_ADDR_STRAP_LO, a);
      u_master.stop_cond();
      chk("strap ack", 16'(a), 16'(i[0] ^ i[1]));
    end
    e = 16'h0103 ^ 16'h5aa5;
    u_master.start_cond();
    u_master.put_byte(8'hbb, a);
    u_master.get_byte(1'b1, d);
    u_master.stop_cond();
    chk("alt read ack", 16'(a), 16'h0);
    chk("alt read byte", 16'(d), 16'(e[15:8]));
    chk("ptr held", addr, 16'h0103);
  endtask : t_strap

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("reset ptr", addr, TWS_PTR_RESET);
    chk("reset busy", 16'(busy), 16'h0);
    t_write();
    t_seq_write();
    t_rand_read();
    t_cur_read();
    t_strap();
    test_done();
  end

  // about 2450 cycles of traffic expected
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    test_done();
  end
endmodule : tws_slave_bench

`default_nettype wire
